//--- hw/i2cec_pkg.sv
package i2cec_pkg;

  // Register word offsets on the 2-bit address port
  localparam logic [1:0] I2CEC_OFS_CTRL = 2'h0;
  localparam logic [1:0] I2CEC_OFS_ST1 = 2'h1;
  localparam logic [1:0] I2CEC_OFS_ST2 = 2'h2;
  localparam logic [1:0] I2CEC_OFS_DATA = 2'h3;

  // control_reg fields
  localparam int I2CEC_CTL_PE = 5;
  localparam int I2CEC_CTL_GC = 4;
  localparam int I2CEC_CTL_START = 3;
  localparam int I2CEC_CTL_ACK = 2;
  localparam int I2CEC_CTL_STOP = 1;
  localparam int I2CEC_CTL_ITE = 0;

  // status_reg_one fields
  localparam int I2CEC_ST1_EVF = 7;
  localparam int I2CEC_ST1_HDR = 6;
  localparam int I2CEC_ST1_DIR = 5;
  localparam int I2CEC_ST1_BUSY = 4;
  localparam int I2CEC_ST1_BTF = 3;
  localparam int I2CEC_ST1_ADDR_MATCH_FLAG = 2;
  localparam int I2CEC_ST1_ROLE = 1;
  localparam int I2CEC_ST1_SB = 0;

  // status_reg_two fields, bits 7:5 read as zero
  localparam int I2CEC_ST2_AF = 4;
  localparam int I2CEC_ST2_STOP_SEEN_FLAG = 3;
  localparam int I2CEC_ST2_ARB_LOST_FLAG = 2;
  localparam int I2CEC_ST2_MISPLACED_COND_FLAG = 1;
  localparam int I2CEC_ST2_GCAL = 0;

  // Reset values and special bytes
  localparam logic [7:0] I2CEC_REG_RST = 8'h00;
  localparam logic [7:0] I2CEC_BYTE_RELEASE = 8'hFF;
  localparam logic [7:0] I2CEC_ADDR_GCALL = 8'h00;
  localparam logic [7:0] I2CEC_ADDR_IGNORE = 8'h01;
  localparam logic I2CEC_LINE_IDLE = 1'b1;

  // Pin synchroniser depth before any logic reads a bus line
  localparam int I2CEC_SYNC_STAGES = 2;

  // Status-read then data/control access handshake
  typedef enum logic [1:0] {
    I2CEC_SEQ_IDLE = 2'b01,
    I2CEC_SEQ_ARMED = 2'b10
  } i2cec_seq_t;

endpackage

//--- hw/i2cec_line_sync.sv
`timescale 1ns/10ps
`default_nettype none
module i2cec_line_sync import i2cec_pkg::*; #(
  parameter int W = 2
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // Raw lines and synchronised view
  input wire logic [W-1:0] line_in,
  output logic [W-1:0] line_now,
  output logic [W-1:0] line_prev
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } i2cec_sync_t;

  i2cec_sync_t s_reg;
  i2cec_sync_t s_next;

  // The meta stage feeds only the sync stage
  always_comb begin
    s_next = s_reg;
    if (ce) begin
      s_next.meta = line_in;
      s_next.sync = s_reg.meta;
      s_next.prev = s_reg.sync;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_reg <= {(I2CEC_SYNC_STAGES + 1) * W{I2CEC_LINE_IDLE}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign line_now = s_reg.sync;
  assign line_prev = s_reg.prev;

endmodule
`default_nettype wire

//--- hw/i2cec_top.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Address match sets event and match flags; status one read clears both.
// - Byte received sets event and done; status one read then data read clears.
// - Byte sent sets event and done; status one read then data write clears.
// - Slave nack sets fail and done; done clears by stop toggle or FFh.
// - Slave stop detect sets event and stop flag; status two read clears.
// - Start sent sets event and start flag; status read then data write clears.
// - Address sent sets event; status one read then control write clears.
// - Header sent sets flag; status read then data write of second byte clears.
// - Interface runs on in wait; any interrupt event wakes the processor.
// - Halt freezes registers, no acknowledge, events cannot wake.
// - One interrupt, raised only with irq_enable set and global mask clear.
// - periph_on low clears control and status except end request, frees pins.
// - gencall_enable acknowledges address 00h, never 01h; cleared when off.
// - A slave addressed by general call only receives, never transmits.
// - Begin request makes repeated or bus-free start; cleared when sent or off.
// - reply_enable returns acknowledges after bytes; cleared when off.
// - Master end request sends stop, cleared once sent, survives periph_on low.
// - Slave end request releases lines after current byte; software clears it.
// - SCL held low while header, start, done, match or address event pend.
// - Event flag summarises all events; error events clear on status two read.
// - Direction shows sent or received byte; clears with done, stop, arb loss.
// - Bus busy sets on start detect, clears on stop detect or bus error.
module i2cec_top import i2cec_pkg::*; (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // Register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  // Processor state
  input wire logic halt_mode,
  input wire logic global_irq_mask,
  output logic irq_req,
  // Bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic pins_on,
  // Bit engine events, one-cycle pulses on mclk
  input wire logic ev_addr_match,
  input wire logic ev_gencall,
  input wire logic ev_byte_rx,
  input wire logic ev_byte_tx,
  input wire logic ev_nack,
  input wire logic ev_start_sent,
  input wire logic ev_header_sent,
  input wire logic ev_addr_sent,
  input wire logic ev_arb_lost,
  input wire logic ev_misplaced,
  input wire logic ev_stop_sent,
  input wire logic [7:0] rx_byte,
  // Bit engine controls
  output logic [7:0] tx_byte,
  output logic tx_load,
  output logic gen_start,
  output logic gen_stop,
  output logic release_lines,
  output logic ack_en,
  output logic gc_ack,
  output logic slave_tx_ok
);

  typedef struct packed {
    logic ctl_pe;
    logic ctl_gc;
    logic ctl_start;
    logic ctl_ack;
    logic ctl_stop;
    logic ctl_ite;
    logic event_flag;
    logic hdr;
    logic dir;
    logic busy;
    logic byte_done_flag;
    logic addr_match_flag;
    logic role;
    logic sb;
    logic af;
    logic stop_seen_flag;
    logic arb_lost_flag;
    logic misplaced_cond_flag;
    logic gcal;
    logic ev6;
    i2cec_seq_t seq;
    logic stop_prev;
    logic suppress;
    logic [7:0] data;
    logic [7:0] rdata;
    logic tx_load;
    logic irq;
    logic scl_oe_n;
    logic release_l;
    logic gen_start;
    logic gen_stop;
    logic ack_en;
    logic gc_ack;
    logic tx_ok;
  } i2cec_state_t;

  i2cec_state_t st;
  i2cec_state_t nx;

  logic [1:0] line_now;
  logic [1:0] line_prev;
  logic start_det;
  logic stop_det;

  i2cec_line_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .line_in({scl_in, sda_in}),
    .line_now(line_now),
    .line_prev(line_prev)
  );

  // Index 1 is SCL, index 0 is SDA
  assign start_det = line_now[1] && line_prev[1] && line_prev[0]
                     && !line_now[0];
  assign stop_det = line_now[1] && line_prev[1] && !line_prev[0]
                    && line_now[0];

  logic wr_ctl;
  logic wr_dat;
  logic rd_st1;
  logic rd_st2;
  logic rd_dat;
  logic armed;
  logic stop_fall;
  logic [7:0] st1_val;
  logic [7:0] st2_val;

  assign wr_ctl = wr_stb && addr == I2CEC_OFS_CTRL;
  assign wr_dat = wr_stb && addr == I2CEC_OFS_DATA;
  assign rd_st1 = rd_stb && addr == I2CEC_OFS_ST1;
  assign rd_st2 = rd_stb && addr == I2CEC_OFS_ST2;
  assign rd_dat = rd_stb && addr == I2CEC_OFS_DATA;
  assign armed = st.seq == I2CEC_SEQ_ARMED;
  assign stop_fall = st.stop_prev && !st.ctl_stop;

  always_comb begin
    st1_val = I2CEC_REG_RST;
    st1_val[I2CEC_ST1_EVF] = st.event_flag;
    st1_val[I2CEC_ST1_HDR] = st.hdr;
    st1_val[I2CEC_ST1_DIR] = st.dir && st.byte_done_flag;
    st1_val[I2CEC_ST1_BUSY] = st.busy;
    st1_val[I2CEC_ST1_BTF] = st.byte_done_flag;
    st1_val[I2CEC_ST1_ADDR_MATCH_FLAG] = st.addr_match_flag;
    st1_val[I2CEC_ST1_ROLE] = st.role;
    st1_val[I2CEC_ST1_SB] = st.sb;
    st2_val = I2CEC_REG_RST;
    st2_val[I2CEC_ST2_AF] = st.af;
    st2_val[I2CEC_ST2_STOP_SEEN_FLAG] = st.stop_seen_flag;
    st2_val[I2CEC_ST2_ARB_LOST_FLAG] = st.arb_lost_flag;
    st2_val[I2CEC_ST2_MISPLACED_COND_FLAG] = st.misplaced_cond_flag;
    st2_val[I2CEC_ST2_GCAL] = st.gcal;
  end

  always_comb begin
    nx = st;
    nx.rdata = I2CEC_REG_RST;
    nx.tx_load = 1'b0;
    if (ce && halt_mode) begin
      // Registers frozen; nothing acknowledged, no wake request
      nx.ack_en = 1'b0;
      nx.gc_ack = 1'b0;
      nx.irq = 1'b0;
      nx.rdata = st.rdata;
    end else if (ce) begin
      // Register reads, answered in the next cycle only
      unique case (addr)
        I2CEC_OFS_CTRL: nx.rdata = {2'h0, st.ctl_pe, st.ctl_gc, st.ctl_start,
                                    st.ctl_ack, st.ctl_stop, st.ctl_ite};
        I2CEC_OFS_ST1: nx.rdata = st1_val;
        I2CEC_OFS_ST2: nx.rdata = st2_val;
        I2CEC_OFS_DATA: nx.rdata = st.data;
      endcase
      if (!rd_stb) begin
        nx.rdata = I2CEC_REG_RST;
      end
      // Control writes; while off, only periph_on is taken
      if (wr_ctl) begin
        nx.ctl_pe = wdata[I2CEC_CTL_PE];
        if (st.ctl_pe) begin
          nx.ctl_gc = wdata[I2CEC_CTL_GC];
          nx.ctl_start = wdata[I2CEC_CTL_START];
          nx.ctl_ack = wdata[I2CEC_CTL_ACK];
          nx.ctl_stop = wdata[I2CEC_CTL_STOP];
          nx.ctl_ite = wdata[I2CEC_CTL_ITE];
        end
      end
      if (wr_dat) begin
        nx.data = wdata;
        nx.tx_load = st.ctl_pe;
      end else if (ev_byte_rx) begin
        nx.data = rx_byte;
      end
      // Handshake: a status read arms, the next data access or control write fires
      if (rd_st1 || rd_st2) begin
        nx.seq = I2CEC_SEQ_ARMED;
      end else if (armed && (wr_dat || rd_dat || wr_ctl)) begin
        nx.seq = I2CEC_SEQ_IDLE;
      end
      // Clears first, then sets, so a same-cycle event wins
      if (rd_st1) begin
        nx.addr_match_flag = 1'b0;
        nx.af = 1'b0;
      end
      if (armed && rd_dat) begin
        nx.byte_done_flag = 1'b0;
      end
      if (armed && wr_dat) begin
        nx.byte_done_flag = 1'b0;
        nx.sb = 1'b0;
        nx.hdr = 1'b0;
      end
      if (armed && wr_ctl) begin
        nx.ev6 = 1'b0;
      end
      if (wr_dat && wdata == I2CEC_BYTE_RELEASE && !st.role && st.dir) begin
        nx.byte_done_flag = 1'b0;
      end
      if (stop_fall && st.byte_done_flag && !st.role) begin
        nx.byte_done_flag = 1'b0;
        nx.suppress = 1'b1;
      end
      if (rd_st2) begin
        nx.af = 1'b0;
        nx.stop_seen_flag = 1'b0;
        nx.arb_lost_flag = 1'b0;
        nx.misplaced_cond_flag = 1'b0;
      end
      if (!nx.byte_done_flag || stop_det || ev_arb_lost) begin
        nx.dir = 1'b0;
      end
      if (stop_det || ev_arb_lost) begin
        nx.role = 1'b0;
        nx.gcal = 1'b0;
      end
      if (stop_det || ev_misplaced) begin
        nx.busy = 1'b0;
      end
      if (start_det) begin
        nx.busy = 1'b1;
        nx.suppress = 1'b0;
        nx.release_l = 1'b0;
      end
      if (stop_det && !st.role) begin
        nx.stop_seen_flag = !st.suppress;
        nx.suppress = 1'b0;
      end
      if (ev_start_sent) begin
        nx.ctl_start = 1'b0;
        nx.sb = 1'b1;
        nx.role = 1'b1;
      end
      if (ev_stop_sent && st.role) begin
        nx.ctl_stop = 1'b0;
      end
      if (ev_addr_match) begin
        nx.addr_match_flag = 1'b1;
        nx.gcal = ev_gencall && st.ctl_gc;
      end
      if (ev_byte_rx) begin
        nx.byte_done_flag = 1'b1;
        nx.dir = 1'b0;
      end
      if (ev_byte_tx) begin
        nx.byte_done_flag = 1'b1;
        nx.dir = 1'b1;
      end
      if (ev_nack) begin
        nx.af = 1'b1;
        nx.byte_done_flag = nx.byte_done_flag || !st.role;
        nx.dir = nx.dir || !st.role;
      end
      if (ev_header_sent) begin
        nx.hdr = 1'b1;
      end
      if (ev_addr_sent) begin
        nx.ev6 = 1'b1;
      end
      if (ev_arb_lost) begin
        nx.arb_lost_flag = 1'b1;
      end
      if (ev_misplaced) begin
        nx.misplaced_cond_flag = 1'b1;
      end
      // Slave release after the current byte, held until the next start
      if (!st.role && st.ctl_stop && st.byte_done_flag) begin
        nx.release_l = 1'b1;
      end
      // One cycle behind the end request, so a high-to-low toggle is seen
      nx.stop_prev = st.ctl_stop;
      // Disabled: every control and status bit but the end request returns to reset; the data byte keeps its value
      if (!nx.ctl_pe) begin
        nx.ctl_gc = 1'b0;
        nx.ctl_start = 1'b0;
        nx.ctl_ack = 1'b0;
        nx.ctl_ite = 1'b0;
        nx.hdr = 1'b0;
        nx.dir = 1'b0;
        nx.busy = 1'b0;
        nx.byte_done_flag = 1'b0;
        nx.addr_match_flag = 1'b0;
        nx.role = 1'b0;
        nx.sb = 1'b0;
        nx.af = 1'b0;
        nx.stop_seen_flag = 1'b0;
        nx.arb_lost_flag = 1'b0;
        nx.misplaced_cond_flag = 1'b0;
        nx.gcal = 1'b0;
        nx.ev6 = 1'b0;
        nx.suppress = 1'b0;
        nx.release_l = 1'b0;
        nx.seq = I2CEC_SEQ_IDLE;
      end
      nx.event_flag = nx.hdr || nx.byte_done_flag || nx.addr_match_flag || nx.sb || nx.af || nx.stop_seen_flag
               || nx.arb_lost_flag || nx.misplaced_cond_flag || nx.ev6;
      // Same request also wakes the processor from wait
      nx.irq = nx.event_flag && nx.ctl_ite && !global_irq_mask;
      nx.scl_oe_n = !(nx.ctl_pe && (nx.hdr || nx.sb || nx.byte_done_flag || nx.addr_match_flag
                                    || nx.ev6));
      // Start in slave role waits for a free bus
      nx.gen_start = nx.ctl_pe && nx.ctl_start
                     && (nx.role || !nx.busy);
      nx.gen_stop = nx.ctl_pe && nx.role && nx.ctl_stop;
      nx.ack_en = nx.ctl_pe && nx.ctl_ack;
      // Own-address 01h never acknowledged, whatever the mode
      nx.gc_ack = nx.ctl_pe && nx.ctl_ack && nx.ctl_gc
                  && rx_byte == I2CEC_ADDR_GCALL
                  && rx_byte != I2CEC_ADDR_IGNORE;
      nx.tx_ok = !nx.gcal;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '0;
      st.seq <= I2CEC_SEQ_IDLE;
      st.scl_oe_n <= 1'b1;
      st.tx_ok <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign rdata = st.rdata;
  assign irq_req = st.irq;
  assign scl_out = 1'b0;
  assign scl_oe_n = st.scl_oe_n;
  assign pins_on = st.ctl_pe;
  assign tx_byte = st.data;
  assign tx_load = st.tx_load;
  assign gen_start = st.gen_start;
  assign gen_stop = st.gen_stop;
  assign release_lines = st.release_l;
  assign ack_en = st.ack_en;
  assign gc_ack = st.gc_ack;
  assign slave_tx_ok = st.tx_ok;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic go;
  assign go = ce && !halt_mode;

  a_irq_needs_enable: assert property (
    irq_req |-> st.ctl_ite && st.event_flag)
    else $error("irq raised without enable or event");
  a_off_clears_all: assert property (
    !st.ctl_pe |-> !st.event_flag && !st.byte_done_flag && !st.sb && !st.ctl_ite
                   && !st.ctl_ack && !st.ctl_gc && scl_oe_n)
    else $error("state left set while disabled");
  a_scl_hold_cause: assert property (
    !scl_oe_n |-> st.ctl_pe && (st.byte_done_flag || st.sb || st.addr_match_flag || st.hdr
                                || st.ev6))
    else $error("scl held low without a pending flag");
  a_match_clear: assert property (
    go && rd_st1 && !ev_addr_match |=> !st.addr_match_flag)
    else $error("match flag survived status one read");
  a_rx_sets_done: assert property (
    go && st.ctl_pe && ev_byte_rx && !wr_ctl |=> st.byte_done_flag && st.event_flag && !st.dir)
    else $error("received byte did not set done");
  a_stop_flag_clear: assert property (
    go && rd_st2 && !stop_det |=> !st.stop_seen_flag)
    else $error("stop flag survived status two read");
  a_busy_on_start: assert property (
    go && st.ctl_pe && start_det && !wr_ctl |=> st.busy)
    else $error("busy not set after start");
  a_start_sent: assert property (
    go && st.ctl_pe && ev_start_sent && !wr_ctl
    |=> !st.ctl_start && st.sb && st.role)
    else $error("start request not cleared when sent");
  a_halt_frozen: assert property (
    ce && halt_mode |=> !ack_en && !irq_req && $stable(st.event_flag)
                         && $stable(st.byte_done_flag))
    else $error("state moved or ack given in halt");
  a_master_stop_clr: assert property (
    go && st.role && ev_stop_sent && !wr_ctl |=> !st.ctl_stop)
    else $error("end request not cleared after stop sent");
  a_gc_ack_enable: assert property (
    gc_ack |-> st.ctl_gc && st.ctl_pe)
    else $error("general call acknowledged while disabled");

  c_irq_raised: cover property (!irq_req ##1 irq_req);
  c_rx_cleared: cover property (st.byte_done_flag && !st.dir ##[1:40] !st.byte_done_flag);
  c_slave_release: cover property (!release_lines ##1 release_lines);
  c_busy_cycle: cover property (!st.busy ##1 st.busy ##[1:400] !st.busy);

endmodule
`default_nettype wire

//--- bench/i2cec_peer.sv
`timescale 1ns/10ps
`default_nettype none
module i2cec_peer (
  // Wired bus level and this device's open-drain drives
  input wire logic scl_line,
  output logic scl_drv,
  output logic sda_drv
);
  // Lines idle released, pulled high; the link clock only runs inside frames
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic frame(input int nbits);
    sda_drv = 1'b0;
    #62.5;
    for (int i = 0; i < nbits; i++) begin
      scl_drv = 1'b0;
      #31;
      sda_drv = 1'($urandom);
      #31.5;
      scl_drv = 1'b1;
      // Respect clock stretching before counting the high phase
      wait (scl_line);
      #62.5;
    end
    scl_drv = 1'b0;
    #31;
    sda_drv = 1'b0;
    #31.5;
    scl_drv = 1'b1;
    #62.5;
    sda_drv = 1'b1;
    #125;
  endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import i2cec_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic halt_mode = 1'b0;
  logic global_irq_mask = 1'b0;
  logic [10:0] ev = 11'h000;
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] rdata, tx_byte, b;
  logic irq_req, scl_out, scl_oe_n, pins_on, tx_load, gen_start, gen_stop;
  logic release_lines, ack_en, gc_ack, slave_tx_ok, scl_drv, sda_drv;
  wire logic scl_line = scl_drv & (scl_oe_n | scl_out);
  int num_errors = 0;
  int n_tests = 0;

  initial forever #5 mclk = ~mclk;

  i2cec_peer peer (.scl_line(scl_line), .scl_drv(scl_drv), .sda_drv(sda_drv));

  i2cec_top dut (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .halt_mode(halt_mode), .global_irq_mask(global_irq_mask),
    .irq_req(irq_req), .scl_in(scl_line), .sda_in(sda_drv),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .pins_on(pins_on),
    .ev_addr_match(ev[0]), .ev_gencall(ev[1]), .ev_byte_rx(ev[2]),
    .ev_byte_tx(ev[3]), .ev_nack(ev[4]), .ev_start_sent(ev[5]),
    .ev_header_sent(ev[6]), .ev_addr_sent(ev[7]), .ev_arb_lost(ev[8]),
    .ev_misplaced(ev[9]), .ev_stop_sent(ev[10]), .rx_byte(rx_byte),
    .tx_byte(tx_byte), .tx_load(tx_load), .gen_start(gen_start),
    .gen_stop(gen_stop), .release_lines(release_lines), .ack_en(ack_en),
    .gc_ack(gc_ack), .slave_tx_ok(slave_tx_ok));

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h got %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask

  // Masked read; rdata is only valid in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] m,
                    input logic [7:0] e, input string n);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    chk(n, e, rdata & m);
  endtask

  task automatic evp(input int i);
    @(posedge mclk);
    ev <= 11'h001 << i;
    @(posedge mclk);
    ev <= 11'h000;
    #1;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    conclude();
  end

  initial begin
    void'($urandom(32'h5A8CA701));
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 4; a++) rd(2'(a), 8'hFF, 8'h00, "reset");
    $display("reset values done");

    wr(I2CEC_OFS_CTRL, 8'h35);
    rd(I2CEC_OFS_CTRL, 8'hFF, 8'h20, "first ctrl");
    wr(I2CEC_OFS_CTRL, 8'h35);
    rd(I2CEC_OFS_CTRL, 8'hFF, 8'h35, "second ctrl");
    chk("ack_en", 8'h01, ack_en);
    chk("pins_on", 8'h01, pins_on);
    $display("enable done");

    evp(0);
    chk("stretch", 8'h00, scl_oe_n);
    chk("scl_out", 8'h00, scl_out);
    chk("irq", 8'h01, irq_req);
    global_irq_mask <= 1'b1;
    cyc(2);
    chk("irq masked", 8'h00, irq_req);
    global_irq_mask <= 1'b0;
    rd(I2CEC_OFS_ST1, 8'hFF, 8'h84, "match st1");
    rd(I2CEC_OFS_ST1, 8'hFF, 8'h00, "match clr");
    chk("release", 8'h01, scl_oe_n);
    $display("address match done");

    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      rx_byte <= b;
      evp(2);
      rd(I2CEC_OFS_ST1, 8'hFF, 8'h88, "rx st1");
      rd(I2CEC_OFS_DATA, 8'hFF, b, "rx data");
      rd(I2CEC_OFS_ST1, 8'hFF, 8'h00, "rx clr");
    end
    $display("receive done");

    evp(3);
    rd(I2CEC_OFS_ST1, 8'hFF, 8'hA8, "tx st1");
    b = 8'($urandom);
    wr(I2CEC_OFS_DATA, b);
    chk("tx_load", 8'h01, tx_load);
    cyc(1);
    chk("tx_byte", b, tx_byte);
    chk("tx_load end", 8'h00, tx_load);
    rd(I2CEC_OFS_ST1, 8'hFF, 8'h00, "tx clr");
    $display("transmit done");

    evp(4);
    rd(I2CEC_OFS_ST2, 8'hFF, 8'h10, "nack st2");
    rd(I2CEC_OFS_ST2, 8'hFF, 8'h00, "nack af clr");
    // Disarm first so that only the FFh write can clear done
    wr(I2CEC_OFS_CTRL, 8'h35);
    wr(I2CEC_OFS_DATA, I2CEC_BYTE_RELEASE);
    rd(I2CEC_OFS_ST1, 8'hFF, 8'h00, "nack done clr");
    evp(4);
    wr(I2CEC_OFS_CTRL, 8'h37);
    wr(I2CEC_OFS_CTRL, 8'h35);
    rd(I2CEC_OFS_ST1, 8'h08, 8'h00, "nack stop clr");
    chk("release_lines", 8'h01, release_lines);
    evp(9);
    rd(I2CEC_OFS_ST2, 8'h02, 8'h02, "bus err");
    rd(I2CEC_OFS_ST1, 8'h80, 8'h00, "err evf clr");
    $display("errors done");

    @(posedge mclk);
    ev <= 11'h003;
    @(posedge mclk);
    ev <= 11'h000;
    #1;
    chk("slave_tx_ok", 8'h00, slave_tx_ok);
    rd(I2CEC_OFS_ST2, 8'h01, 8'h01, "gcal set");
    rd(I2CEC_OFS_ST1, 8'hFF, 8'h84, "gc match");

    for (int v = 0; v < 2; v++) begin
      rx_byte <= 8'(v);
      cyc(3);
      chk("gc_ack", (v == 0) ? 8'h01 : 8'h00, gc_ack);
    end
    $display("general call done");

    fork
      peer.frame(3);
      begin
        #200;
        rd(I2CEC_OFS_ST1, 8'h10, 8'h10, "busy set");
      end
    join
    rd(I2CEC_OFS_ST2, 8'h08, 8'h08, "stop seen");
    rd(I2CEC_OFS_ST2, 8'h08, 8'h00, "stop clr");
    rd(I2CEC_OFS_ST1, 8'h10, 8'h00, "busy clr");
    chk("slave_tx_ok back", 8'h01, slave_tx_ok);
    $display("bus frame done");

    wr(I2CEC_OFS_CTRL, 8'h3D);
    cyc(1);
    chk("gen_start", 8'h01, gen_start);
    evp(5);
    rd(I2CEC_OFS_CTRL, 8'hFF, 8'h35, "start clr");
    rd(I2CEC_OFS_ST1, 8'hFF, 8'h83, "sb set");
    wr(I2CEC_OFS_DATA, 8'($urandom));
    rd(I2CEC_OFS_ST1, 8'h01, 8'h00, "sb clr");
    evp(7);
    chk("addr stretch", 8'h00, scl_oe_n);
    rd(I2CEC_OFS_ST1, 8'h80, 8'h80, "addr sent");
    wr(I2CEC_OFS_CTRL, 8'h35);
    chk("addr release", 8'h01, scl_oe_n);
    rd(I2CEC_OFS_ST1, 8'h80, 8'h00, "addr sent clr");
    evp(6);
    rd(I2CEC_OFS_ST1, 8'hC0, 8'hC0, "hdr set");
    wr(I2CEC_OFS_DATA, 8'($urandom));
    rd(I2CEC_OFS_ST1, 8'hC0, 8'h00, "hdr clr");
    wr(I2CEC_OFS_CTRL, 8'h37);
    cyc(1);
    chk("gen_stop", 8'h01, gen_stop);
    evp(10);
    rd(I2CEC_OFS_CTRL, 8'hFF, 8'h35, "stop bit clr");
    evp(8);
    rd(I2CEC_OFS_ST2, 8'h04, 8'h04, "arb lost");
    rd(I2CEC_OFS_ST1, 8'h82, 8'h00, "arb role clr");
    $display("master done");

    halt_mode <= 1'b1;
    cyc(1);
    evp(2);
    cyc(1);
    chk("halt ack", 8'h00, ack_en);
    halt_mode <= 1'b0;
    rd(I2CEC_OFS_ST1, 8'h08, 8'h00, "halt frozen");
    $display("halt done");

    wr(I2CEC_OFS_CTRL, 8'h37);
    evp(0);
    // End request written as one so that its survival is visible
    wr(I2CEC_OFS_CTRL, 8'h02);
    rd(I2CEC_OFS_CTRL, 8'hFF, 8'h02, "off ctrl");
    rd(I2CEC_OFS_ST1, 8'hFF, 8'h00, "off st1");
    chk("pins off", 8'h00, pins_on);
    chk("ack off", 8'h00, ack_en);
    $display("disable done");
    conclude();
  end
endmodule
`default_nettype wire
